// [rtl/synth_cfg.svh]
/*
  Register selects, field positions, reset values and timing constants of
  the synthesizer output and lock configuration bank.
  Assumes inclusion by bare name from package and modules.
*/
`ifndef SYNTH_CFG_SVH
`define SYNTH_CFG_SVH

// Register select codes in the four low bits of a serial word
`define SEL_OUTPUT_BLEED 4'h6
`define SEL_LOCK_DETECT 4'h7
`define SEL_FIXED_CONFIG 4'h8
`define SEL_BAND_TIMERS 4'h9
`define SEL_TUNING_ADC 4'hA
`define SEL_MSB 3
`define SEL_LSB 0
`define WORD_BITS 32

// Output and bleed register
`define OB_NEG_BLEED 29
`define OB_OUT2_FUND 25
`define OB_FB_SEL 24
`define OB_DIV_MSB 23
`define OB_DIV_LSB 21
`define OB_BLEED_MSB 20
`define OB_BLEED_LSB 13
`define OB_MUTE_LOCK 11
`define OB_OUT2_DIS 9
`define OB_OUT2_PWR_MSB 8
`define OB_OUT2_PWR_LSB 7
`define OB_OUT1_EN 6
`define OB_OUT1_PWR_MSB 5
`define OB_OUT1_PWR_LSB 4

// Lock detect and load sync register
`define LD_SYNC_EDGE 27
`define LD_RESYNC 25
`define LD_CYC_MSB 9
`define LD_CYC_LSB 8
`define LD_LOL 7
`define LD_FRAC_MSB 6
`define LD_FRAC_LSB 5
`define LD_PRECISION 4

// Band select timer register
`define BT_DIV_MSB 31
`define BT_DIV_LSB 24
`define BT_TO_MSB 23
`define BT_TO_LSB 14
`define BT_ALC_MSB 13
`define BT_ALC_LSB 9
`define BT_SLT_MSB 8
`define BT_SLT_LSB 4

// Lock window lengths in tenths of a nanosecond
`define WIN_INT_N 7'd29
`define WIN_FRAC_0 7'd50
`define WIN_FRAC_1 7'd60
`define WIN_FRAC_2 7'd80
`define WIN_FRAC_3 7'd120

// Reset values
`define RST_WORD 32'h00000000
`define RST_DIV 3'h0
`define RST_WIN 7'd50

`endif

// [rtl/synth_pkg.sv]
/*
  Types shared by the serial receiver and the configuration bank.
  Assumes synth_cfg.svh on the include path.
*/
package synth_pkg;
  `include "synth_cfg.svh"

  typedef enum logic [0:0] {
    SYNC_IDLE = 1'b0,
    SYNC_WAIT = 1'b1
  } sync_e;

  typedef struct packed {
    logic negBleedEnable;
    logic out2FundamentalSelect;
    logic feedbackSourceSelect;
    logic [2:0] outputDividerSelect;
    logic [7:0] bleedCurrentLevel;
    logic muteUntilLocked;
    logic out2Disable;
    logic [1:0] out2PowerLevel;
    logic out1Enable;
    logic [1:0] out1PowerLevel;
  } rf_ctrl_s;

  typedef struct packed {
    logic loadSyncEdgeChoice;
    logic loadStrobeResync;
    logic [1:0] lockCycleCount;
    logic refLossLockMode;
    logic [1:0] fracLockWindow;
    logic lockWindowPrecision;
    logic [6:0] lockWindowTenthsNs;
  } lock_ctrl_s;

  typedef struct packed {
    logic [7:0] bandDivisionValue;
    logic [9:0] bandSelectTimeout;
    logic [4:0] levelCalWait;
    logic [4:0] synthLockTimeout;
  } band_ctrl_s;

  typedef struct packed {
    logic serialClkPrev;
    logic loadStrobePrev;
    logic [31:0] shift;
    logic [31:0] word;
    logic wordValid;
  } shifter_state_s;
endpackage

// [rtl/serial_word_shifter.sv]
/*
  Three-wire serial receiver: shifts data MSB first on each rising
  serial clock edge and presents the last 32 bits when load enable rises.
  Assumes all pins synchronous to clk and slower than clk.
*/
`timescale 1ns/1ps
module serial_word_shifter
  import synth_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadStrobe,
  output logic [31:0] word,
  output logic wordValid
);

  shifter_state_s cur;
  shifter_state_s next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.serialClkPrev = serialClk;
    next_cur.loadStrobePrev = loadStrobe;
    next_cur.wordValid = 1'b0;
    if (serialClk && !cur.serialClkPrev)
    begin
      next_cur.shift = {cur.shift[30:0], serialData};
    end
    if (loadStrobe && !cur.loadStrobePrev)
    begin
      next_cur.word = cur.shift;
      next_cur.wordValid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign word = cur.word;
  assign wordValid = cur.wordValid;

  property p_valid_on_strobe;
    @(posedge clk) disable iff (rst)
    (loadStrobe && !cur.loadStrobePrev) |=> wordValid ##1 !wordValid;
  endproperty
  a_valid_on_strobe: assert property (p_valid_on_strobe)
    else $error("word not presented for one cycle after load strobe");

endmodule

// [rtl/synth_output_lock_config_regs.sv]
/*
  Serially programmed configuration bank for the output/bleed, lock
  detect, fixed, band select timer and tuning ADC registers.
  Assumes a host drives the three-wire port synchronously to clk, and that
  lock status, reference level, double buffer enable and the frequency
  register 0 write pulse come from neighbouring logic.
*/
// Notes on behaviour
// - Output bit 29 turns constant negative bleed on or off.
// - Bit 25 set sends VCO fundamental to second output, else mirrors.
// - Bit 24 picks feedback straight from VCO or after dividers.
// - Bits 23:21 choose the output divider ratio.
// - Bits 20:13 set bleed current added to charge pump.
// - Bit 11 keeps RF outputs unpowered until lock is reported.
// - Second output enable is active low: 1 disables.
// - Bit 6 enables the first RF output.
// - Bits 8:7 and 5:4 set second and first output power.
// - Low four bits of a word select the target register.
// - Lock bit 25 aligns the load to a reference edge.
// - Lock bit 27 picks the reference edge, only when resync on.
// - Lock bits 9:8 set consecutive in-window cycles before lock.
// - Lock bit 7 selects loss-of-lock mode.
// - Lock bits 6:5 pick 5, 6, 8 or 12 ns window.
// - Lock bit 4 forces a 2.9 ns integer-N window.
// - Band timer word holds band division and band timeout.
// - With double buffering, divider select waits for register 0.
`timescale 1ns/1ps
module synth_output_lock_config_regs
  import synth_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadStrobe,
  input wire logic referenceInput,
  input wire logic lockDetected,
  input wire logic doubleBufferEnable,
  input wire logic freqReg0Write,
  output rf_ctrl_s rfCtrl,
  output lock_ctrl_s lockCtrl,
  output band_ctrl_s bandCtrl,
  output logic [31:0] fixedConfigWord,
  output logic [31:0] tuningAdcWord,
  output logic primaryRfPowered,
  output logic secondaryRfPowered,
  output logic loadApplied
);

  typedef struct packed {
    rf_ctrl_s rf;
    lock_ctrl_s lock;
    band_ctrl_s band;
    logic [31:0] fixedWord;
    logic [31:0] adcWord;
    logic [2:0] pendingDiv;
    sync_e syncState;
    logic [31:0] heldWord;
    logic refPrev;
    logic out1On;
    logic out2On;
    logic applied;
  } bank_state_s;

  bank_state_s cur, next_cur;
  logic [31:0] rxWord, commitWord;
  logic rxValid, refRise, refFall, edgeHit, commit;
  logic [3:0] commitSel;

  ////////////////////////////////////////////////////////////////////////
  serial_word_shifter rx (
    .clk(clk),
    .rst(rst),
    .serialClk(serialClk),
    .serialData(serialData),
    .loadStrobe(loadStrobe),
    .word(rxWord),
    .wordValid(rxValid)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] window_of(input logic precision,
                                           input logic [1:0] frac);
    logic [6:0] w;
    w = `WIN_FRAC_0;
    if (precision)
    begin
      w = `WIN_INT_N;
    end
    else
    begin
      case (frac)
        2'h0: w = `WIN_FRAC_0;
        2'h1: w = `WIN_FRAC_1;
        2'h2: w = `WIN_FRAC_2;
        2'h3: w = `WIN_FRAC_3;
        default: w = `WIN_FRAC_0;
      endcase
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign refRise = referenceInput && !cur.refPrev;
  assign refFall = !referenceInput && cur.refPrev;
  // Edge choice matters only while resync is on; 1 picks the falling edge
  assign edgeHit = cur.lock.loadSyncEdgeChoice ? refFall : refRise;

  always_comb
  begin
    commit = 1'b0;
    commitWord = rxWord;
    if (cur.syncState == SYNC_WAIT)
    begin
      commit = edgeHit;
      commitWord = cur.heldWord;
    end
    else if (rxValid && !cur.lock.loadStrobeResync)
    begin
      commit = 1'b1;
    end
  end

  assign commitSel = commitWord[`SEL_MSB:`SEL_LSB];

  always_comb
  begin
    next_cur = cur;
    next_cur.refPrev = referenceInput;
    next_cur.applied = commit;
    case (cur.syncState)
      SYNC_IDLE:
      begin
        if (rxValid && cur.lock.loadStrobeResync)
        begin
          next_cur.heldWord = rxWord;
          next_cur.syncState = SYNC_WAIT;
        end
      end
      SYNC_WAIT:
      begin
        // A newer word replaces one still waiting for its edge
        if (rxValid)
        begin
          next_cur.heldWord = rxWord;
        end
        if (edgeHit && !rxValid)
        begin
          next_cur.syncState = SYNC_IDLE;
        end
      end
      default: next_cur.syncState = SYNC_IDLE;
    endcase
    if (commit)
    begin
      case (commitSel)
        `SEL_OUTPUT_BLEED:
        begin
          next_cur.rf.negBleedEnable = commitWord[`OB_NEG_BLEED];
          next_cur.rf.out2FundamentalSelect =
            commitWord[`OB_OUT2_FUND];
          next_cur.rf.feedbackSourceSelect = commitWord[`OB_FB_SEL];
          next_cur.pendingDiv = commitWord[`OB_DIV_MSB:`OB_DIV_LSB];
          if (!doubleBufferEnable)
          begin
            next_cur.rf.outputDividerSelect =
              commitWord[`OB_DIV_MSB:`OB_DIV_LSB];
          end
          next_cur.rf.bleedCurrentLevel =
            commitWord[`OB_BLEED_MSB:`OB_BLEED_LSB];
          next_cur.rf.muteUntilLocked = commitWord[`OB_MUTE_LOCK];
          next_cur.rf.out2Disable = commitWord[`OB_OUT2_DIS];
          next_cur.rf.out2PowerLevel =
            commitWord[`OB_OUT2_PWR_MSB:`OB_OUT2_PWR_LSB];
          next_cur.rf.out1Enable = commitWord[`OB_OUT1_EN];
          next_cur.rf.out1PowerLevel =
            commitWord[`OB_OUT1_PWR_MSB:`OB_OUT1_PWR_LSB];
        end
        `SEL_LOCK_DETECT:
        begin
          next_cur.lock.loadSyncEdgeChoice = commitWord[`LD_SYNC_EDGE];
          next_cur.lock.loadStrobeResync = commitWord[`LD_RESYNC];
          next_cur.lock.lockCycleCount =
            commitWord[`LD_CYC_MSB:`LD_CYC_LSB];
          next_cur.lock.refLossLockMode = commitWord[`LD_LOL];
          next_cur.lock.fracLockWindow = commitWord[`LD_FRAC_MSB:`LD_FRAC_LSB];
          next_cur.lock.lockWindowPrecision = commitWord[`LD_PRECISION];
          next_cur.lock.lockWindowTenthsNs = window_of(
            commitWord[`LD_PRECISION],
            commitWord[`LD_FRAC_MSB:`LD_FRAC_LSB]);
        end
        `SEL_FIXED_CONFIG: next_cur.fixedWord = commitWord;
        `SEL_BAND_TIMERS:
        begin
          next_cur.band.bandDivisionValue =
            commitWord[`BT_DIV_MSB:`BT_DIV_LSB];
          next_cur.band.bandSelectTimeout =
            commitWord[`BT_TO_MSB:`BT_TO_LSB];
          next_cur.band.levelCalWait = commitWord[`BT_ALC_MSB:`BT_ALC_LSB];
          next_cur.band.synthLockTimeout =
            commitWord[`BT_SLT_MSB:`BT_SLT_LSB];
        end
        `SEL_TUNING_ADC: next_cur.adcWord = commitWord;
        default: next_cur.applied = 1'b0;
      endcase
    end
    // Buffered divider select moves only on a frequency register 0 write
    if (freqReg0Write && doubleBufferEnable)
    begin
      next_cur.rf.outputDividerSelect = cur.pendingDiv;
    end
    next_cur.out1On = cur.rf.out1Enable &&
      (!cur.rf.muteUntilLocked || lockDetected);
    next_cur.out2On = !cur.rf.out2Disable &&
      (!cur.rf.muteUntilLocked || lockDetected);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.lock.lockWindowTenthsNs <= `RST_WIN;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign rfCtrl = cur.rf;
  assign lockCtrl = cur.lock;
  assign bandCtrl = cur.band;
  assign fixedConfigWord = cur.fixedWord;
  assign tuningAdcWord = cur.adcWord;
  assign primaryRfPowered = cur.out1On;
  assign secondaryRfPowered = cur.out2On;
  assign loadApplied = cur.applied;

  ////////////////////////////////////////////////////////////////////////
  sequence s_resync_load;
    rxValid && cur.lock.loadStrobeResync && cur.syncState == SYNC_IDLE;
  endsequence
  sequence s_held_until_edge;
    !loadApplied ##1 (cur.syncState == SYNC_WAIT || loadApplied);
  endsequence

  property p_resync_waits;
    @(posedge clk) disable iff (rst)
    s_resync_load |=> s_held_until_edge;
  endproperty
  a_resync_waits: assert property (p_resync_waits)
    else $error("resynchronised load applied before reference edge");

  property p_edge_commits;
    @(posedge clk) disable iff (rst)
    (cur.syncState == SYNC_WAIT && edgeHit &&
     cur.heldWord[3:0] == `SEL_FIXED_CONFIG) |=>
      loadApplied && fixedConfigWord == $past(cur.heldWord);
  endproperty
  a_edge_commits: assert property (p_edge_commits)
    else $error("held word not applied on chosen reference edge");

  property p_div_direct;
    @(posedge clk) disable iff (rst)
    (commit && commitSel == `SEL_OUTPUT_BLEED && !doubleBufferEnable &&
     !freqReg0Write) |=>
      rfCtrl.outputDividerSelect == $past(commitWord[23:21]);
  endproperty
  a_div_direct: assert property (p_div_direct)
    else $error("divider select not taken directly");

  property p_div_buffered;
    @(posedge clk) disable iff (rst)
    (doubleBufferEnable && !freqReg0Write) |=>
      $stable(rfCtrl.outputDividerSelect);
  endproperty
  a_div_buffered: assert property (p_div_buffered)
    else $error("buffered divider select moved without register 0 write");

  property p_mute_out1;
    @(posedge clk) disable iff (rst)
    (rfCtrl.muteUntilLocked && !lockDetected && $stable(rfCtrl)) |=>
      !primaryRfPowered && !secondaryRfPowered;
  endproperty
  a_mute_out1: assert property (p_mute_out1)
    else $error("RF output powered before lock while muted");

  property p_out2_low_enable;
    @(posedge clk) disable iff (rst)
    (!rfCtrl.muteUntilLocked && $stable(rfCtrl.out2Disable) &&
     $stable(rfCtrl.muteUntilLocked)) |=>
      secondaryRfPowered == !$past(rfCtrl.out2Disable);
  endproperty
  a_out2_low_enable: assert property (p_out2_low_enable)
    else $error("second output enable polarity wrong");

  property p_int_window;
    @(posedge clk) disable iff (rst)
    lockCtrl.lockWindowPrecision |-> lockCtrl.lockWindowTenthsNs == 7'd29;
  endproperty
  a_int_window: assert property (p_int_window)
    else $error("integer-N window is not 2.9 ns");

  property p_unmapped_ignored;
    @(posedge clk) disable iff (rst)
    (commit && commitSel == 4'hB && !freqReg0Write) |=>
      !loadApplied && $stable(rfCtrl) && $stable(lockCtrl) &&
      $stable(bandCtrl);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored)
    else $error("word for another register changed this bank");

  property p_band_fields;
    @(posedge clk) disable iff (rst)
    (commit && commitSel == `SEL_BAND_TIMERS) |=>
      bandCtrl.bandDivisionValue == $past(commitWord[31:24]) &&
      bandCtrl.bandSelectTimeout == $past(commitWord[23:14]);
  endproperty
  a_band_fields: assert property (p_band_fields)
    else $error("band timer fields not loaded");
  property p_neg_bleed;
    @(posedge clk) disable iff (rst)
    (commit && commitSel == `SEL_OUTPUT_BLEED) |=>
      rfCtrl.negBleedEnable == $past(commitWord[29]) &&
      rfCtrl.bleedCurrentLevel == $past(commitWord[20:13]);
  endproperty
  a_neg_bleed: assert property (p_neg_bleed)
    else $error("bleed fields not loaded");

endmodule

// [verification/host_serial_model.sv]
/*
  Host side model of the three-wire programming port.
  Assumes the bench clock on clk; pins change 1 ns after its rising edge.
*/
`timescale 1ns/1ps
module host_serial_model
(
  input wire logic clk,
  output logic serialClk,
  output logic serialData,
  output logic loadStrobe
);
  initial
  begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Clock idles low between frames; data then shows a stale inverse
  task automatic send(input logic [31:0] w);
    tick(1);
    for (int i = 31; i >= 0; i--)
    begin
      serialData = w[i];
      serialClk = 1'b1;
      tick(2);
      serialClk = 1'b0;
      tick(2);
    end
    serialData = ~w[0];
    loadStrobe = 1'b1;
    tick(2);
    loadStrobe = 1'b0;
  endtask
endmodule

// [verification/testbench.sv]
/*
  Self-checking bench for the configuration bank: serial writes through
  the host model, then comparisons of the decoded outputs.
  Assumes the host model and the bank on one 125 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import synth_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic serialClk, serialData, loadStrobe;
  logic referenceInput = 1'b0;
  logic lockDetected = 1'b0;
  logic doubleBufferEnable = 1'b0;
  logic freqReg0Write = 1'b0;
  rf_ctrl_s rfCtrl, c1, c2, c3;
  lock_ctrl_s lockCtrl;
  band_ctrl_s bandCtrl;
  logic [31:0] fixedConfigWord, tuningAdcWord, bw;
  logic primaryRfPowered, secondaryRfPowered, loadApplied;
  logic [6:0] win [4] = '{7'h32, 7'h3C, 7'h50, 7'h78};
  int err_total = 0;
  int tests_run = 0;
  int applyCnt = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  host_serial_model host (.clk(clk), .serialClk(serialClk),
    .serialData(serialData), .loadStrobe(loadStrobe));

  synth_output_lock_config_regs i_dut (.clk(clk), .rst(rst),
    .serialClk(serialClk), .serialData(serialData),
    .loadStrobe(loadStrobe), .referenceInput(referenceInput),
    .lockDetected(lockDetected),
    .doubleBufferEnable(doubleBufferEnable),
    .freqReg0Write(freqReg0Write), .rfCtrl(rfCtrl), .lockCtrl(lockCtrl),
    .bandCtrl(bandCtrl), .fixedConfigWord(fixedConfigWord),
    .tuningAdcWord(tuningAdcWord), .primaryRfPowered(primaryRfPowered),
    .secondaryRfPowered(secondaryRfPowered), .loadApplied(loadApplied));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Pulse counter: a one-cycle apply cannot be missed by a late poll
  always @(posedge clk)
  begin
    cycles++;
    if (loadApplied === 1'b1)
      applyCnt++;
    if (cycles == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [31:0] w, input int ap);
    int c0;
    c0 = applyCnt;
    host.send(w);
    tick(8);
    chk(32'(applyCnt - c0), 32'(ap));
  endtask

  task automatic refTo(input logic v);
    referenceInput = v;
    tick(4);
  endtask

  function automatic logic [31:0] obw(input rf_ctrl_s c);
    obw = 32'h14000006;
    obw[29] = c.negBleedEnable;
    obw[25] = c.out2FundamentalSelect;
    obw[24] = c.feedbackSourceSelect;
    obw[23:21] = c.outputDividerSelect;
    obw[20:13] = c.bleedCurrentLevel;
    obw[11] = c.muteUntilLocked;
    obw[9] = c.out2Disable;
    obw[8:7] = c.out2PowerLevel;
    obw[6] = c.out1Enable;
    obw[5:4] = c.out1PowerLevel;
  endfunction

  function automatic logic [31:0] lkw(input logic e, input logic r,
    input logic [1:0] f, input logic p);
    lkw = {4'h0, e, 1'b1, r, 15'h0, f, f[0], f, p, 4'h7};
  endfunction

  function automatic lock_ctrl_s lke(input logic e, input logic r,
    input logic [1:0] f, input logic p);
    lke = {e, r, f, f[0], f, p, p ? 7'h1D : win[f]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(16);
    rst = 1'b0;
    tick(3);
    chk(32'(rfCtrl), 32'h0);
    chk(32'(lockCtrl), 32'(lke(0, 0, 2'h0, 0)));
    chk(32'(bandCtrl), 32'h0);
    chk(fixedConfigWord, 32'h0);
    chk(32'({primaryRfPowered, secondaryRfPowered}), 32'h1);
    // Bleed on only while fractional and PFD at or below 100 MHz
    c1 = '{1'b1, 1'b1, 1'b1, 3'h5, 8'hA5, 1'b0, 1'b1, 2'h2, 1'b1, 2'h3};
    wr(obw(c1), 1);
    chk(32'(rfCtrl), 32'(c1));
    chk(32'({primaryRfPowered, secondaryRfPowered}), 32'h2);
    c2 = '{1'b0, 1'b0, 1'b0, 3'h2, 8'h5A, 1'b1, 1'b0, 2'h1, 1'b1, 2'h0};
    wr(obw(c2), 1);
    chk(32'(rfCtrl), 32'(c2));
    chk(32'({primaryRfPowered, secondaryRfPowered}), 32'h0);
    lockDetected = 1'b1;
    tick(3);
    chk(32'({primaryRfPowered, secondaryRfPowered}), 32'h3);
    // Divider select parked until the frequency register 0 write
    doubleBufferEnable = 1'b1;
    c3 = c2;
    c3.outputDividerSelect = 3'h7;
    wr(obw(c3), 1);
    chk(32'(rfCtrl.outputDividerSelect), 32'h2);
    freqReg0Write = 1'b1;
    tick(1);
    freqReg0Write = 1'b0;
    tick(2);
    chk(32'(rfCtrl), 32'(c3));
    wr(32'h1234567B, 0);
    chk(32'(rfCtrl), 32'(c3));
    wr(32'h00C0000A, 1);
    chk(tuningAdcWord, 32'h00C0000A);
    for (int i = 0; i < 4; i++)
    begin
      wr(lkw(0, 0, 2'(i), 0), 1);
      chk(32'(lockCtrl), 32'(lke(0, 0, 2'(i), 0)));
    end
    wr(lkw(0, 1, 2'h1, 1), 1);
    chk(32'(lockCtrl), 32'(lke(0, 1, 2'h1, 1)));
    // Resync on, rising edge: a word waits for the reference to rise
    bw = {8'hC3, 10'h2A5, 5'h11, 5'h0B, 4'h9};
    wr(bw, 0);
    chk(32'(bandCtrl), 32'h0);
    refTo(1'b1);
    chk(32'(bandCtrl), 32'({8'hC3, 10'h2A5, 5'h11, 5'h0B}));
    wr(lkw(1, 1, 2'h2, 0), 0);
    refTo(1'b0);
    chk(32'(lockCtrl), 32'(lke(0, 1, 2'h1, 1)));
    refTo(1'b1);
    chk(32'(lockCtrl), 32'(lke(1, 1, 2'h2, 0)));
    refTo(1'b0);
    wr(32'h15596568, 0);
    refTo(1'b1);
    chk(fixedConfigWord, 32'h0);
    refTo(1'b0);
    chk(fixedConfigWord, 32'h15596568);
    wr(lkw(1, 0, 2'h3, 0), 0);
    refTo(1'b1);
    refTo(1'b0);
    chk(32'(lockCtrl), 32'(lke(1, 0, 2'h3, 0)));
    close_out();
  end
endmodule
